/* File: rtl/pbo_defines.svh */
// Function
// - Mute set ramps gain to zero, 245 samples
// - Mute cleared ramps gain to 0 dB, 245 samples
// - Early release reverses ramp from current gain
// - Enable cleared: manual after zero-cross timeout
// - Reference 28 is +6 dB, volume 91 is 0 dB
// - Line output off when routing bit clear
// - Line gain bit: 0 dB or +2 dB
// - Power and save clear: line pulled down
// - Power set, save clear, routing bit set: line active
// - Speaker power clear: both pins at ground
// - Speaker enable clear: pins forced to ground
// - Speaker gain bit: 0 dB or +2 dB
// - Reference field 1.5 dB steps, 24h 0 dB
`ifndef PBO_DEFINES_SVH
`define PBO_DEFINES_SVH

// -----------------------------------------------------------------------------
// Register offsets (byte addresses).
// -----------------------------------------------------------------------------
`define PBO_OFS_CTRL    8'h00
`define PBO_OFS_LCCFG   8'h04
`define PBO_OFS_LEVEL   8'h08
`define PBO_OFS_STATUS  8'h0C

// -----------------------------------------------------------------------------
// Control register fields.
// -----------------------------------------------------------------------------
`define PBO_CTRL_SOFT_MUTE   0
`define PBO_CTRL_REC_LC_EN   1
`define PBO_CTRL_PLAY_LC_EN  2
`define PBO_CTRL_FILT_PWR    3
`define PBO_CTRL_DAC_LINE    4
`define PBO_CTRL_LINE_GAIN   5
`define PBO_CTRL_LINE_PWR    6
`define PBO_CTRL_LINE_SAVE   7
`define PBO_CTRL_SPK_GAIN    8
`define PBO_CTRL_SPK_PWR     9
`define PBO_CTRL_SPK_OUT_EN  10
`define PBO_CTRL_DAC_PWR     11
`define PBO_CTRL_WIDTH       12
`define PBO_CTRL_RESET       12'h000

// -----------------------------------------------------------------------------
// Level-control configuration fields and reset value.
// -----------------------------------------------------------------------------
`define PBO_CFG_ZTM_LSB      0
`define PBO_CFG_WTM_LSB      2
`define PBO_CFG_LMTH_LSB     5
`define PBO_CFG_LMAT_LSB     7
`define PBO_CFG_RGAIN_LSB    9
`define PBO_CFG_LIMITER_ZERO_CROSS_DIS_BIT     11
`define PBO_CFG_RFST_LSB     12
`define PBO_CFG_FAST_LIMITER_EN_BIT     14
`define PBO_CFG_WIDTH        15
`define PBO_CFG_RESET        15'h0000

// -----------------------------------------------------------------------------
// Level register fields and reset values.
// -----------------------------------------------------------------------------
`define PBO_LVL_OREF_LSB     0
`define PBO_LVL_OVOL_LSB     8
`define PBO_LVL_IREF_LSB     16
`define PBO_OREF_RESET       6'h28
`define PBO_OVOL_RESET       8'h91
`define PBO_IREF_RESET       8'hC5

// -----------------------------------------------------------------------------
// Gain codes and timing.
// -----------------------------------------------------------------------------
`define PBO_OREF_ZERO_DB     8'h24
`define PBO_OVOL_ZERO_DB     8'h91
`define PBO_OREF_TO_OVOL     4
`define PBO_MUTE_STEPS       245
`define PBO_ZTM_BASE         128
`define PBO_CLK_HZ           10000000
`define PBO_FS_HZ            8000

`endif

/* File: rtl/pbo_pkg.sv */
package pbo_pkg;

   // Level-control mode, one-hot.
   typedef enum logic [2:0] {
      PBO_LC_MANUAL  = 3'b001,
      PBO_LC_ACTIVE  = 3'b010,
      PBO_LC_EXITING = 3'b100
   } pbo_lc_state_e;

endpackage

/* File: rtl/pbo_soft_mute.sv */
`timescale 1ns/100ps
`include "pbo_defines.svh"

module pbo_soft_mute #(
   parameter int SW = 16
) (
   input  wire logic          ref_clk,     // System clock.
   input  wire logic          arst_n,      // Asynchronous reset, active low.
   input  wire logic          fs_tick,     // One pulse per sample period.
   input  wire logic          mute,        // Soft-mute request.
   input  wire logic [SW-1:0] sample_in,   // Incoming playback sample.
   output logic      [SW-1:0] sample_out,  // Attenuated sample, registered.
   output logic      [7:0]    gain_out,    // Present ramp step, registered.
   output logic               busy         // Ramp in progress, registered.
);

   // -----------------------------------------------------------------------------
   // Ramp step and attenuation scale.
   // -----------------------------------------------------------------------------
   localparam logic [7:0]  GAIN_MAX = 8'(`PBO_MUTE_STEPS);
   // Rounded down so a scaled sample never exceeds its input.
   localparam logic [16:0] RECIP    = 17'(65536 / `PBO_MUTE_STEPS);

   logic [7:0]          gain_q;
   logic signed [SW+8:0]  prod_g;
   logic signed [SW+26:0] prod_s;

   // Step gain once per sample toward the target; a release mid-ramp turns back.
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         gain_q <= GAIN_MAX;
      end else if (fs_tick) begin
         if (mute && gain_q != 8'h00) begin
            gain_q <= gain_q - 8'h01;
         end else if (!mute && gain_q != GAIN_MAX) begin
            gain_q <= gain_q + 8'h01;
         end
      end
   end

   // Scale the sample by the ramp step over the full step count.
   always_comb begin
      prod_g = $signed(sample_in) * $signed({1'b0, gain_q});
      prod_s = prod_g * $signed({1'b0, RECIP});
   end

   // Register the scaled sample; full gain passes the sample untouched.
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         sample_out <= '0;
      end else if (fs_tick) begin
         if (gain_q == GAIN_MAX) begin
            sample_out <= sample_in;
         end else begin
            sample_out <= prod_s[SW+15:16];
         end
      end
   end

   // Export ramp state.
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         gain_out <= GAIN_MAX;
         busy     <= 1'b0;
      end else begin
         gain_out <= gain_q;
         busy     <= mute ? (gain_q != 8'h00) : (gain_q != GAIN_MAX);
      end
   end

endmodule

/* File: rtl/pbo_top.sv */
// The Wishbone slave port and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
`include "pbo_defines.svh"

module pbo_top #(
   parameter int SW     = 16,
   parameter int FS_DIV = `PBO_CLK_HZ / `PBO_FS_HZ
) (
   input  wire logic          ref_clk,              // System clock, 10 MHz.
   input  wire logic          arst_n,               // Asynchronous reset, active low.
   input  wire logic          wb_cyc_i,             // Wishbone cycle.
   input  wire logic          wb_stb_i,             // Wishbone strobe.
   input  wire logic          wb_we_i,              // Wishbone write enable.
   input  wire logic [7:0]    wb_adr_i,             // Wishbone byte address.
   input  wire logic [3:0]    wb_sel_i,             // Wishbone byte selects.
   input  wire logic [31:0]   wb_dat_i,             // Wishbone write data.
   output logic      [31:0]   wb_dat_o,             // Wishbone read data.
   output logic               wb_ack_o,             // Wishbone acknowledge.
   input  wire logic [SW-1:0] sample_in,            // Playback sample, taken per tick.
   output logic      [SW-1:0] sample_out,           // Soft-muted sample.
   output logic               sample_tick,          // Sample-rate pulse.
   output logic      [7:0]    play_gain_code,       // Volume code in use.
   output logic               level_ctl_auto,       // Level control in charge.
   output logic               line_out_pin_en,      // Line output driving.
   output logic               line_out_pin_pulldn,  // Line output pulled down.
   output logic               line_out_ramping,     // Line in power-save ramp.
   output logic               line_gain_2db,        // Line gain +2 dB.
   output logic               speaker_out_pos_gnd,  // Positive pin held at ground.
   output logic               speaker_out_neg_gnd,  // Negative pin held at ground.
   output logic               speaker_amp_on,       // Speaker amplifier running.
   output logic               speaker_gain_2db      // Speaker gain +2 dB.
);

   // -----------------------------------------------------------------------------
   // Control and configuration storage.
   // -----------------------------------------------------------------------------
   logic [`PBO_CTRL_WIDTH-1:0] ctrl_q;
   logic [`PBO_CFG_WIDTH-1:0]  cfg_q;
   logic [5:0]                 oref_q;
   logic [7:0]                 ovol_q;
   logic [7:0]                 iref_q;
   logic                       wr_en;
   logic                       rd_en;
   logic [31:0]                wmask;
   logic [31:0]                ctrl_w;
   logic [31:0]                cfg_w;
   logic [31:0]                lvl_w;
   logic [31:0]                status_w;
   logic [31:0]                rd_d;

   // Accept one access per request; ack is high for a single cycle.
   assign wr_en = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
   assign rd_en = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o;

   // Byte-lane mask built from the selects.
   genvar b;
   generate
      for (b = 0; b < 4; b++) begin : g_lane
         assign wmask[8*b+7:8*b] = {8{wb_sel_i[b]}};
      end
   endgenerate

   // Present register words with byte-lane merge applied.
   assign ctrl_w = (32'(ctrl_q) & ~wmask) | (wb_dat_i & wmask);
   assign cfg_w  = (32'(cfg_q) & ~wmask) | (wb_dat_i & wmask);
   assign lvl_w  = ({8'h00, iref_q, ovol_q, 2'b00, oref_q} & ~wmask) | (wb_dat_i & wmask);

   // Acknowledge every access, mapped or not, one cycle after it is seen.
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
      end
   end

   // Control register.
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         ctrl_q <= `PBO_CTRL_RESET;
      end else if (wr_en && wb_adr_i == `PBO_OFS_CTRL) begin
         ctrl_q <= ctrl_w[`PBO_CTRL_WIDTH-1:0];
      end
   end

   // Level-control configuration; the host keeps it still while running.
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         cfg_q <= `PBO_CFG_RESET;
      end else if (wr_en && wb_adr_i == `PBO_OFS_LCCFG) begin
         cfg_q <= cfg_w[`PBO_CFG_WIDTH-1:0];
      end
   end

   // Reference and volume levels.
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         oref_q <= `PBO_OREF_RESET;
         ovol_q <= `PBO_OVOL_RESET;
         iref_q <= `PBO_IREF_RESET;
      end else if (wr_en && wb_adr_i == `PBO_OFS_LEVEL) begin
         oref_q <= lvl_w[`PBO_LVL_OREF_LSB +: 6];
         ovol_q <= lvl_w[`PBO_LVL_OVOL_LSB +: 8];
         iref_q <= lvl_w[`PBO_LVL_IREF_LSB +: 8];
      end
   end

   // -----------------------------------------------------------------------------
   // Sample-rate divider.
   // -----------------------------------------------------------------------------
   localparam int DW = $clog2(FS_DIV);
   logic [DW-1:0] div_q;
   logic          tick;

   assign tick = (div_q == DW'(FS_DIV - 1));

   // Free-running count yields one enable pulse per sample period.
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         div_q <= '0;
      end else begin
         div_q <= tick ? '0 : div_q + DW'(1);
      end
   end

   // Registered copy of the tick for the outside.
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         sample_tick <= 1'b0;
      end else begin
         sample_tick <= tick;
      end
   end

   // -----------------------------------------------------------------------------
   // Soft mute.
   // -----------------------------------------------------------------------------
   logic [7:0] mute_gain;
   logic       mute_busy;

   pbo_soft_mute #(
      .SW (SW)
   ) u_mute (
      .ref_clk    (ref_clk),
      .arst_n     (arst_n),
      .fs_tick    (tick),
      .mute       (ctrl_q[`PBO_CTRL_SOFT_MUTE]),
      .sample_in  (sample_in),
      .sample_out (sample_out),
      .gain_out   (mute_gain),
      .busy       (mute_busy)
   );

   // -----------------------------------------------------------------------------
   // Level-control mode sequencing.
   // -----------------------------------------------------------------------------
   pbo_pkg::pbo_lc_state_e lc_q;
   pbo_pkg::pbo_lc_state_e lc_d;
   logic                   lc_run;
   logic                   lc_en_any;
   logic [10:0]            zc_cnt_q;
   logic [10:0]            zc_limit;

   assign lc_en_any = ctrl_q[`PBO_CTRL_REC_LC_EN] || ctrl_q[`PBO_CTRL_PLAY_LC_EN];
   assign lc_run    = lc_en_any && ctrl_q[`PBO_CTRL_FILT_PWR];
   // Timeout of 128, 256, 512 or 1024 samples.
   assign zc_limit  = 11'(`PBO_ZTM_BASE) << cfg_q[`PBO_CFG_ZTM_LSB +: 2];

   // Next mode; filter power off ends the mode at once.
   always_comb begin
      lc_d = lc_q;
      unique case (lc_q)
         pbo_pkg::PBO_LC_MANUAL: begin
            if (lc_run) begin
               lc_d = pbo_pkg::PBO_LC_ACTIVE;
            end
         end
         pbo_pkg::PBO_LC_ACTIVE: begin
            if (!ctrl_q[`PBO_CTRL_FILT_PWR]) begin
               lc_d = pbo_pkg::PBO_LC_MANUAL;
            end else if (!lc_en_any) begin
               lc_d = pbo_pkg::PBO_LC_EXITING;
            end
         end
         pbo_pkg::PBO_LC_EXITING: begin
            if (lc_run) begin
               lc_d = pbo_pkg::PBO_LC_ACTIVE;
            end else if (!ctrl_q[`PBO_CTRL_FILT_PWR]) begin
               lc_d = pbo_pkg::PBO_LC_MANUAL;
            end else if (tick && zc_cnt_q >= zc_limit - 11'd1) begin
               lc_d = pbo_pkg::PBO_LC_MANUAL;
            end
         end
         default: begin
            lc_d = pbo_pkg::PBO_LC_MANUAL;
         end
      endcase
   end

   // Mode register.
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         lc_q <= pbo_pkg::PBO_LC_MANUAL;
      end else begin
         lc_q <= lc_d;
      end
   end

   // Zero-cross timeout counter, in samples, runs only while exiting.
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         zc_cnt_q <= '0;
      end else if (lc_q != pbo_pkg::PBO_LC_EXITING) begin
         zc_cnt_q <= '0;
      end else if (tick) begin
         zc_cnt_q <= zc_cnt_q + 11'd1;
      end
   end

   // -----------------------------------------------------------------------------
   // Reference level to volume code.
   // -----------------------------------------------------------------------------
   logic [8:0] ref_vol;
   logic [7:0] gain_d;

   // Each reference step is four volume steps; 24h maps to the 0 dB code.
   assign ref_vol = 9'(`PBO_OVOL_ZERO_DB)
                  + 9'({3'b000, oref_q} * `PBO_OREF_TO_OVOL)
                  - 9'(`PBO_OREF_ZERO_DB * `PBO_OREF_TO_OVOL);

   // Under level control, volume is capped at the reference gain.
   always_comb begin
      gain_d = ovol_q;
      if (lc_q != pbo_pkg::PBO_LC_MANUAL && {1'b0, ovol_q} > ref_vol) begin
         gain_d = ref_vol[7:0];
      end
   end

   // Registered gain and mode flags.
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         play_gain_code <= `PBO_OVOL_RESET;
         level_ctl_auto <= 1'b0;
      end else begin
         play_gain_code <= gain_d;
         level_ctl_auto <= (lc_q != pbo_pkg::PBO_LC_MANUAL);
      end
   end

   // -----------------------------------------------------------------------------
   // Line output and speaker control.
   // -----------------------------------------------------------------------------
   logic line_pwr;
   logic line_save;
   logic spk_pwr;
   logic spk_en;

   assign line_pwr  = ctrl_q[`PBO_CTRL_LINE_PWR];
   assign line_save = ctrl_q[`PBO_CTRL_LINE_SAVE];
   assign spk_pwr   = ctrl_q[`PBO_CTRL_SPK_PWR];
   assign spk_en    = ctrl_q[`PBO_CTRL_SPK_OUT_EN];

   // Line output state; the save bit holds the slow ramp during changes.
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         line_out_pin_en     <= 1'b0;
         line_out_pin_pulldn <= 1'b1;
         line_out_ramping    <= 1'b0;
         line_gain_2db       <= 1'b0;
      end else begin
         line_out_pin_en     <= ctrl_q[`PBO_CTRL_DAC_LINE] && line_pwr
                                && !line_save;
         line_out_pin_pulldn <= !line_pwr && !line_save;
         line_out_ramping    <= line_save;
         line_gain_2db       <= ctrl_q[`PBO_CTRL_LINE_GAIN];
      end
   end

   // Speaker pins are grounded unless powered and enabled.
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         speaker_out_pos_gnd <= 1'b1;
         speaker_out_neg_gnd <= 1'b1;
         speaker_amp_on      <= 1'b0;
         speaker_gain_2db    <= 1'b0;
      end else begin
         speaker_out_pos_gnd <= !spk_pwr || !spk_en;
         speaker_out_neg_gnd <= !spk_pwr || !spk_en;
         speaker_amp_on      <= spk_pwr;
         speaker_gain_2db    <= ctrl_q[`PBO_CTRL_SPK_GAIN];
      end
   end

   // -----------------------------------------------------------------------------
   // Read path.
   // -----------------------------------------------------------------------------
   // Status: mute gain, ramp busy, mode, and an unpowered DAC feeding the powered, enabled speaker.
   assign status_w = {11'h000,
                      !ctrl_q[`PBO_CTRL_DAC_PWR] && spk_pwr && spk_en,
                      lc_q,
                      mute_busy,
                      play_gain_code,
                      mute_gain};

   // Read data mux; unmapped addresses read zero.
   always_comb begin
      unique case (wb_adr_i)
         `PBO_OFS_CTRL:   rd_d = 32'(ctrl_q);
         `PBO_OFS_LCCFG:  rd_d = 32'(cfg_q);
         `PBO_OFS_LEVEL:  rd_d = {8'h00, iref_q, ovol_q, 2'b00, oref_q};
         `PBO_OFS_STATUS: rd_d = status_w;
         default:         rd_d = 32'h0000_0000;
      endcase
   end

   // Registered read data, captured with the acknowledge.
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         wb_dat_o <= 32'h0000_0000;
      end else if (rd_en) begin
         wb_dat_o <= rd_d;
      end
   end

endmodule

/* File: dv/pbo_load_model.sv */
`timescale 1ns/100ps

module pbo_load_model (
   input  wire logic line_out_pin_en,      // Line output driving.
   input  wire logic line_out_pin_pulldn,  // Line output pulled down.
   input  wire logic speaker_out_pos_gnd,  // Positive pin at ground.
   input  wire logic speaker_out_neg_gnd,  // Negative pin at ground.
   output logic      line_at_gnd,          // Load sees ground on the line.
   output logic      spk_silent            // Speaker sees no drive.
);
   // A released line settles to ground through the load's pull-down.
   assign line_at_gnd = line_out_pin_pulldn | !line_out_pin_en;
   // Both pins at ground leave the speaker silent.
   assign spk_silent = speaker_out_pos_gnd & speaker_out_neg_gnd;
endmodule

/* File: dv/pbo_top_asserts.sv */
`timescale 1ns/100ps

module pbo_top_asserts #(
   parameter int SW     = 16,
   parameter int FS_DIV = 8
) (
   input wire logic          ref_clk,              // Clock.
   input wire logic          arst_n,               // Reset, active low.
   input wire logic          wb_cyc_i,             // Bus cycle.
   input wire logic          wb_stb_i,             // Bus strobe.
   input wire logic          wb_we_i,              // Bus write.
   input wire logic [7:0]    wb_adr_i,             // Bus address.
   input wire logic [3:0]    wb_sel_i,             // Bus lanes.
   input wire logic [31:0]   wb_dat_i,             // Bus write data.
   input wire logic          wb_ack_o,             // Bus acknowledge.
   input wire logic [SW-1:0] sample_out,           // Muted sample.
   input wire logic          sample_tick,          // Sample pulse.
   input wire logic          line_out_pin_en,      // Line driving.
   input wire logic          line_out_pin_pulldn,  // Line pulled down.
   input wire logic          line_gain_2db,        // Line gain.
   input wire logic          speaker_out_pos_gnd,  // Positive pin grounded.
   input wire logic          speaker_out_neg_gnd,  // Negative pin grounded.
   input wire logic          speaker_gain_2db      // Speaker gain.
);
   logic [11:0] ctl_q;
   logic [15:0] tk_q;
   logic [8:0]  mt_q;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!arst_n);
   // Shadow of the control word, loaded at the edge that takes a write.
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         ctl_q <= 12'h000;
      end else if (wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_adr_i == 8'h00) begin
         if (wb_sel_i[0]) ctl_q[7:0] <= wb_dat_i[7:0];
         if (wb_sel_i[1]) ctl_q[11:8] <= wb_dat_i[11:8];
      end
   end
   // Cycles since the last tick; zero until the first tick is seen.
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) tk_q <= 16'h0000;
      else if (sample_tick) tk_q <= 16'h0001;
      else if (tk_q != 16'h0000) tk_q <= tk_q + 16'h0001;
   end
   // Ticks seen while mute is held, saturating well past a full ramp.
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) mt_q <= 9'h000;
      else if (!ctl_q[0]) mt_q <= 9'h000;
      else if (sample_tick && mt_q != 9'h12C) mt_q <= mt_q + 9'h001;
   end
   sequence s_take;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence s_pulse;
      wb_ack_o ##1 !wb_ack_o;
   endsequence
   a_ack_one_cycle: assert property (s_take |=> s_pulse)
      else $error("ack is not a single pulse one cycle after the request");
   a_line_drive: assert property (
      line_out_pin_en == $past(ctl_q[4] & ctl_q[6] & !ctl_q[7]))
      else $error("line drive does not follow route, power and save");
   a_line_pulldown: assert property (
      line_out_pin_pulldn == $past(!ctl_q[6] & !ctl_q[7]))
      else $error("line pull-down does not follow power and save");
   a_line_gain: assert property (line_gain_2db == $past(ctl_q[5]))
      else $error("line gain does not follow its bit");
   a_spk_pos_ground: assert property (
      speaker_out_pos_gnd == $past(!(ctl_q[9] & ctl_q[10])))
      else $error("positive pin ground does not follow power and enable");
   a_spk_pins_pair: assert property (speaker_out_neg_gnd == speaker_out_pos_gnd)
      else $error("speaker pins disagree");
   a_spk_gain: assert property (speaker_gain_2db == $past(ctl_q[8]))
      else $error("speaker gain does not follow its bit");
   a_tick_period: assert property (
      tk_q != 16'h0000 |-> (sample_tick ? tk_q == FS_DIV : tk_q < FS_DIV))
      else $error("sample tick spacing is wrong");
   a_mute_floor: assert property (mt_q > 9'd245 |-> sample_out == '0)
      else $error("sample not silent after a full mute ramp");
endmodule

/* File: dv/playback_output_control_tb.sv */
`timescale 1ns/100ps

module playback_output_control_tb;
   localparam int SW = 16;
   localparam int FS_DIV = 8;
   logic ref_clk = 1'b0, arst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [3:0] sel = 4'h0;
   logic [31:0] dat = 32'h0000_0000, dat_o, q;
   logic [SW-1:0] s_in = 16'h4000, s_out;
   logic ack, tick, auto, l_en, l_pd, l_rmp, l_g, p_g, n_g, amp, s_g, l_gnd, s_sil;
   logic [7:0] code;
   logic [11:0] ctl_t [12] = '{12'h090, 12'h0D0, 12'h050, 12'h040, 12'h060, 12'h0C0,
                               12'h080, 12'h000, 12'hA00, 12'hE00, 12'hF00, 12'hC00};
   logic [7:0] out_t [12] = '{8'h2C, 8'h2C, 8'h8C, 8'h0C, 8'h1C, 8'h2C,
                              8'h2C, 8'h4C, 8'h4E, 8'h42, 8'h43, 8'h4C};
   int n_mismatch = 0, checked = 0;
   pbo_top #(.SW(SW), .FS_DIV(FS_DIV)) pbo_top_i (.ref_clk(ref_clk), .arst_n(arst_n),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
      .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack), .sample_in(s_in), .sample_out(s_out),
      .sample_tick(tick), .play_gain_code(code), .level_ctl_auto(auto),
      .line_out_pin_en(l_en), .line_out_pin_pulldn(l_pd), .line_out_ramping(l_rmp),
      .line_gain_2db(l_g), .speaker_out_pos_gnd(p_g), .speaker_out_neg_gnd(n_g),
      .speaker_amp_on(amp), .speaker_gain_2db(s_g));
   pbo_load_model pbo_load_model_i (.line_out_pin_en(l_en), .line_out_pin_pulldn(l_pd),
      .speaker_out_pos_gnd(p_g), .speaker_out_neg_gnd(n_g), .line_at_gnd(l_gnd),
      .spk_silent(s_sil));
   // Clock at 10 MHz.
   initial begin
      forever #50 ref_clk = ~ref_clk;
   end
   // Prints the counts and the verdict, then ends the run.
   task tally_and_finish;
      $display("checked %0d n_mismatch %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   // One classic bus cycle, held until ack is sampled high.
   task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge ref_clk);
      {cyc, stb, we, adr, dat, sel} <= {2'b11, w, a, d, 4'hF};
      do begin
         @(posedge ref_clk);
         n++;
      end while (ack !== 1'b1 && n < 50);
      q = dat_o;
      {cyc, stb} <= 2'b00;
      if (n >= 50) chk(32'h0000_0000, 32'hFFFF_FFFF);
   endtask
   task rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      wb(1'b0, a, 32'h0000_0000);
      chk(q & m, e);
   endtask
   // Waits for n sample ticks, returning just after the last one.
   task ticks(input int n);
      repeat (n) begin
         @(posedge ref_clk);
         while (tick !== 1'b1) @(posedge ref_clk);
      end
   endtask
   // Writes the control word just after a tick, well before the next one.
   task ctl(input logic [31:0] d);
      ticks(1);
      wb(1'b1, 8'h00, d);
   endtask
   // Watchdog against a hang.
   initial begin
      repeat (40000) @(posedge ref_clk);
      n_mismatch++;
      tally_and_finish;
   end
   // Main sequence.
   initial begin
      repeat (3) @(posedge ref_clk);
      arst_n <= 1'b1;
      rd_chk(8'h00, 32'hFFFF_FFFF, 32'h0000_0000);
      rd_chk(8'h04, 32'hFFFF_FFFF, 32'h0000_0000);
      rd_chk(8'h08, 32'h00FF_FF3F, 32'h00C5_9128);
      rd_chk(8'h0C, 32'h001F_FFFF, 32'h0002_91F5);
      wb(1'b1, 8'h10, 32'hFFFF_FFFF);
      rd_chk(8'h10, 32'hFFFF_FFFF, 32'h0000_0000);
      rd_chk(8'h00, 32'hFFFF_FFFF, 32'h0000_0000);
      ticks(1);
      chk({16'h0000, s_out}, 32'h0000_4000);
      ctl(32'h0000_0001);
      ticks(100);
      rd_chk(8'h0C, 32'h0001_00FF, 32'h0001_0091);
      ctl(32'h0000_0000);
      ticks(50);
      rd_chk(8'h0C, 32'h0001_00FF, 32'h0001_00C2);
      ticks(51);
      rd_chk(8'h0C, 32'h0001_00FF, 32'h0000_00F5);
      ctl(32'h0000_0001);
      ticks(246);
      rd_chk(8'h0C, 32'h0001_00FF, 32'h0000_0000);
      chk({16'h0000, s_out}, 32'h0000_0000);
      ctl(32'h0000_0000);
      ticks(244);
      rd_chk(8'h0C, 32'h0001_00FF, 32'h0001_00F4);
      ticks(1);
      rd_chk(8'h0C, 32'h0001_00FF, 32'h0000_00F5);
      ticks(1);
      chk({16'h0000, s_out}, 32'h0000_4000);
      // Settings are written before level control runs.
      wb(1'b1, 8'h04, 32'h0000_0005);
      wb(1'b1, 8'h08, 32'h00C5_9128);
      ctl(32'h0000_000C);
      rd_chk(8'h0C, 32'h000E_FF00, 32'h0004_9100);
      chk({auto, code}, 32'h0000_0191);
      ctl(32'h0000_0008);
      ticks(250);
      rd_chk(8'h0C, 32'h000E_0000, 32'h0008_0000);
      ticks(10);
      rd_chk(8'h0C, 32'h000E_0000, 32'h0002_0000);
      ctl(32'h0000_000C);
      ctl(32'h0000_0008);
      ctl(32'h0000_0004);
      rd_chk(8'h0C, 32'h000E_0000, 32'h0002_0000);
      ctl(32'h0000_000C);
      rd_chk(8'h0C, 32'h000E_0000, 32'h0004_0000);
      ctl(32'h0000_0000);
      // Line power sequence with pop reduction, then speaker states.
      for (int i = 0; i < 12; i++) begin
         wb(1'b1, 8'h00, {20'h00000, ctl_t[i]});
         @(posedge ref_clk);
         chk({l_gnd, s_sil, l_en, l_pd, l_rmp, l_g, p_g, n_g, amp, s_g},
             {!out_t[i][7], &out_t[i][3:2], out_t[i]});
      end
      tally_and_finish;
   end
endmodule

bind pbo_top pbo_top_asserts #(.SW(SW), .FS_DIV(FS_DIV)) pbo_top_asserts_i (
   .ref_clk(ref_clk), .arst_n(arst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
   .wb_ack_o(wb_ack_o), .sample_out(sample_out), .sample_tick(sample_tick),
   .line_out_pin_en(line_out_pin_en), .line_out_pin_pulldn(line_out_pin_pulldn),
   .line_gain_2db(line_gain_2db), .speaker_out_pos_gnd(speaker_out_pos_gnd),
   .speaker_out_neg_gnd(speaker_out_neg_gnd), .speaker_gain_2db(speaker_gain_2db));
